/* File: hdl/tcc_channel.sv */
/*
 One 16-bit capture/compare timer channel: clock source and
 edge choice, counter clear, two general registers with
 compare output or input capture, plain register port.
 Assumes pins and external clocks are asynchronous to mclk;
 mode and sync inputs come from logic on mclk.
*/
// Summary of operation
// R1 - Clear field picks register A event, register B event, or sync clear
// R2 - Compare-use clear source clears counter on compare match
// R3 - Capture-use clear source clears counter on input capture
// R4 - Sync participation decided by separate sync select input
// R5 - Edge field: 00 rising, 01 falling, 1x both edges
// R6 - Channel 2 phase counting ignores edge field
// R7 - Internal clock counts falling edges of divided clock only
// R8 - External clock counts edges chosen by edge field
// R9 - Source codes 000 to 011 give internal clock /1,/2,/4,/8
// R10 - Source codes 100 to 111 give external clocks A to D
// R11 - Channel 2 phase counting ignores clock source field
// R12 - Each register has three-bit function; top bit selects capture
// R13 - Compare codes: none, drive 0, drive 1, toggle on match
// R14 - Capture codes: rising, falling, both edges; 111 does nothing
// R15 - Register A uses same encoding on its own pin
// R16 - Compare pins drive 0 from reset until first match
// R17 - Channel 2 drives 1 instead of toggling
// R18 - Channels 3 and 4 in paired PWM disregard pin functions
// R19 - Pin function bit 3 reads 1; bit 7 is a free bit
// R20 - Reset gives pin function 0x88 with all fields cleared
// R21 - Each channel instance holds its own pin function register
// R22 - Compare match flag sets when counter equals register
// R23 - Capture copies counter into the capturing register
// R24 - Counter increments by one per qualified clock edge
`timescale 1ns/10ps
module tcc_channel #(
	parameter int CHAN_ID = 0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [15:0] rdData,
	input wire logic [3:0] extClkIn,
	input wire logic pinAIn,
	input wire logic pinBIn,
	output logic pinAOut,
	output logic pinAOe,
	output logic pinBOut,
	output logic pinBOe,
	input wire logic phaseCountMode,
	input wire logic pwmPairMode,
	input wire logic syncSelect,
	input wire logic syncClearIn,
	output logic syncClearOut
);
	// Capture decode for one register
	function automatic logic captureHit(
		input logic [2:0] code,
		input logic r,
		input logic f
	);
		logic hit;
		hit = 1'b0;
		if (code == tcc_pkg::FUNC_IC_RISE) begin
			hit = r; // see R14
		end else if (code == tcc_pkg::FUNC_IC_FALL) begin
			hit = f; // see R14
		end else if (code == tcc_pkg::FUNC_IC_BOTH) begin
			hit = r | f; // see R14
		end
		return hit;
	endfunction : captureHit

	// Pin level after a compare match
	function automatic logic matchLevel(
		input logic [2:0] code,
		input logic cur
	);
		logic lvl;
		lvl = cur;
		if (code == tcc_pkg::FUNC_OC_LOW) begin
			lvl = 1'b0; // see R13
		end else if (code == tcc_pkg::FUNC_OC_HIGH) begin
			lvl = 1'b1; // see R13
		end else if (code == tcc_pkg::FUNC_OC_TOGGLE) begin
			lvl = (CHAN_ID == tcc_pkg::CHAN_PHASE) ? 1'b1 : ~cur; // see R17
		end
		return lvl;
	endfunction : matchLevel

	// Pin drive enable for a function code
	function automatic logic driveOn(input logic [2:0] code);
		return !code[tcc_pkg::FUNC_CAPTURE_BIT] &&
			code != tcc_pkg::FUNC_OC_OFF;
	endfunction : driveOn

	logic [6:0] clkSel_reg;
	logic [6:0] clkSel_next;
	logic [7:0] pinFunc_reg;
	logic [7:0] pinFunc_next;
	logic [15:0] counter_reg;
	logic [15:0] counter_next;
	logic [15:0] genA_reg;
	logic [15:0] genA_next;
	logic [15:0] genB_reg;
	logic [15:0] genB_next;
	logic flagA_reg;
	logic flagA_next;
	logic flagB_reg;
	logic flagB_next;
	logic eqA_reg;
	logic eqB_reg;
	logic pinAOut_reg;
	logic pinAOut_next;
	logic pinBOut_reg;
	logic pinBOut_next;
	logic pinAOe_reg;
	logic pinAOe_next;
	logic pinBOe_reg;
	logic pinBOe_next;
	logic syncClear_reg;
	logic [15:0] rdData_reg;
	logic [15:0] rdData_next;

	// Synchronised pins: ext clocks A..D, capture pins A, B
	logic [5:0] rawIn;
	logic [5:0] pinLvl;
	logic [5:0] pinRise;
	logic [5:0] pinFall;
	assign rawIn = {pinBIn, pinAIn, extClkIn};

	genvar gi;
	generate
		for (gi = 0; gi < tcc_pkg::N_PINS; gi++) begin : gSync
			tcc_pin_sync uSync (
				.mclk(mclk),
				.nrst(nrst),
				.asyncIn(rawIn[gi]),
				.level(pinLvl[gi]),
				.rise(pinRise[gi]),
				.fall(pinFall[gi])
			);
		end
	endgenerate

	// Control fields
	wire [1:0] clrSel = clkSel_reg[tcc_pkg::CLR_LO +: 2];
	wire [1:0] edgeSel = clkSel_reg[tcc_pkg::EDGE_LO +: 2];
	wire [2:0] srcSel = clkSel_reg[tcc_pkg::SRC_LO +: 3];
	wire srcExt = srcSel[tcc_pkg::SRC_EXT_BIT];
	wire [1:0] srcIdx = srcSel[1:0];

	// Internal divided clock
	logic preTick;
	tcc_prescaler uPre (
		.mclk(mclk),
		.nrst(nrst),
		.divSel(srcIdx), // see R9
		.tick(preTick) // see R7
	);

	// External clock edge qualification
	wire extRise = pinRise[srcIdx]; // see R10
	wire extFall = pinFall[srcIdx]; // see R10
	wire extTick = edgeSel[tcc_pkg::EDGE_BOTH_BIT] ? // see R5
		(extRise | extFall) :
		(edgeSel == tcc_pkg::EDGE_FALL) ? extFall : extRise; // see R8

	// Phase counting on ext clocks A and B, channel 2 only
	wire phaseOn = (CHAN_ID == tcc_pkg::CHAN_PHASE) && phaseCountMode;
	wire qaR = pinRise[0];
	wire qaF = pinFall[0];
	wire qbR = pinRise[1];
	wire qbF = pinFall[1];
	wire qaL = pinLvl[0];
	wire qbL = pinLvl[1];
	wire phaseUp = (qaR & ~qbL) | (qaF & qbL) |
		(qbR & qaL) | (qbF & ~qaL);
	wire phaseDown = (qaR & qbL) | (qaF & ~qbL) |
		(qbR & ~qaL) | (qbF & qaL);

	// Count direction; phase mode overrides source and edge
	wire countUp = phaseOn ? phaseUp : // see R6
		srcExt ? extTick : preTick; // see R11
	wire countDown = phaseOn & phaseDown; // see R11

	// Paired PWM disregards pin functions on channels 3 and 4
	wire pwmOff = pwmPairMode && (CHAN_ID == tcc_pkg::CHAN_PWM_LO ||
		CHAN_ID == tcc_pkg::CHAN_PWM_HI);
	wire [2:0] funcA = pwmOff ? tcc_pkg::FUNC_OC_OFF : // see R18
		pinFunc_reg[tcc_pkg::FUNC_A_LO +: 3]; // see R15
	wire [2:0] funcB = pwmOff ? tcc_pkg::FUNC_OC_OFF : // see R18
		pinFunc_reg[tcc_pkg::FUNC_B_LO +: 3]; // see R12
	wire capModeA = funcA[tcc_pkg::FUNC_CAPTURE_BIT]; // see R12
	wire capModeB = funcB[tcc_pkg::FUNC_CAPTURE_BIT]; // see R12

	// Compare on a fresh equality, capture on a pin edge
	wire eqA = counter_reg == genA_reg;
	wire eqB = counter_reg == genB_reg;
	wire matchA = !capModeA && eqA && !eqA_reg; // see R22
	wire matchB = !capModeB && eqB && !eqB_reg; // see R22
	wire capA = captureHit(funcA, pinRise[tcc_pkg::PIN_A_IDX],
		pinFall[tcc_pkg::PIN_A_IDX]); // see R15
	wire capB = captureHit(funcB, pinRise[tcc_pkg::PIN_B_IDX],
		pinFall[tcc_pkg::PIN_B_IDX]); // see R14
	wire eventA = matchA | capA;
	wire eventB = matchB | capB;

	// Counter clear sources
	wire clearOwn = (clrSel == tcc_pkg::CLR_GEN_A && eventA) || // see R2
		(clrSel == tcc_pkg::CLR_GEN_B && eventB); // see R3
	wire clearSync = clrSel == tcc_pkg::CLR_SYNC && // see R1
		syncSelect && syncClearIn; // see R4
	wire clearNow = clearOwn | clearSync;

	// Register port decode
	wire wrClkSel = wrStb && addr == tcc_pkg::REG_CLK_SEL;
	wire wrPinFunc = wrStb && addr == tcc_pkg::REG_PIN_FUNC;
	wire wrCounter = wrStb && addr == tcc_pkg::REG_COUNTER;
	wire wrGenA = wrStb && addr == tcc_pkg::REG_GEN_A;
	wire wrGenB = wrStb && addr == tcc_pkg::REG_GEN_B;
	wire wrFlags = wrStb && addr == tcc_pkg::REG_FLAGS;

	// Control register next values
	assign clkSel_next = wrClkSel ? wrData[6:0] : clkSel_reg;
	assign pinFunc_next = wrPinFunc ? // see R21
		{wrData[tcc_pkg::FUNC_SPARE_BIT], wrData[6:4], 1'b1,
		wrData[2:0]} : pinFunc_reg; // see R19

	// Counter: clear beats software write beats counting
	assign counter_next = clearNow ? 16'h0000 :
		wrCounter ? wrData :
		countUp ? counter_reg + 16'h0001 : // see R24
		countDown ? counter_reg - 16'h0001 :
		counter_reg;

	// General registers: capture beats software write
	assign genA_next = capA ? counter_reg : // see R23
		wrGenA ? wrData : genA_reg;
	assign genB_next = capB ? counter_reg : // see R23
		wrGenB ? wrData : genB_reg;

	// Event flags: a new event wins over a write of 0
	assign flagA_next = eventA | (flagA_reg & // see R22
		~(wrFlags & ~wrData[tcc_pkg::FLAG_A_BIT]));
	assign flagB_next = eventB | (flagB_reg & // see R22
		~(wrFlags & ~wrData[tcc_pkg::FLAG_B_BIT]));

	// Compare pin levels and drive enables
	assign pinAOut_next = matchA ? // see R13
		matchLevel(funcA, pinAOut_reg) : pinAOut_reg;
	assign pinBOut_next = matchB ? // see R13
		matchLevel(funcB, pinBOut_reg) : pinBOut_reg;
	assign pinAOe_next = driveOn(funcA);
	assign pinBOe_next = driveOn(funcB);

	// Read selection; data appears only the cycle after
	wire [15:0] rdClkSel = {8'h00, tcc_pkg::CLK_SEL_FIXED |
		{1'b0, clkSel_reg}};
	wire [15:0] rdPinFunc = {8'h00, pinFunc_reg[7:4], // see R19
		1'b1, pinFunc_reg[2:0]};
	wire [15:0] rdFlags = {14'h0000, flagB_reg, flagA_reg};
	wire [15:0] rdValue =
		(addr == tcc_pkg::REG_CLK_SEL) ? rdClkSel :
		(addr == tcc_pkg::REG_PIN_FUNC) ? rdPinFunc :
		(addr == tcc_pkg::REG_COUNTER) ? counter_reg :
		(addr == tcc_pkg::REG_GEN_A) ? genA_reg :
		(addr == tcc_pkg::REG_GEN_B) ? genB_reg :
		(addr == tcc_pkg::REG_FLAGS) ? rdFlags : 16'h0000;
	assign rdData_next = rdStb ? rdValue : 16'h0000;

	// Control registers; pin function resets to 0x88
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clkSel_reg <= tcc_pkg::CLK_SEL_RST[6:0]; // see R9
			pinFunc_reg <= tcc_pkg::PIN_FUNC_RST; // see R20
		end else begin
			clkSel_reg <= clkSel_next;
			pinFunc_reg <= pinFunc_next;
		end
	end

	// Counter and general registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			counter_reg <= 16'h0000;
			genA_reg <= 16'h0000;
			genB_reg <= 16'h0000;
		end else begin
			counter_reg <= counter_next;
			genA_reg <= genA_next;
			genB_reg <= genB_next;
		end
	end

	// Equality history and event flags; reset value 0 == 0 is no match
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			eqA_reg <= 1'b1;
			eqB_reg <= 1'b1;
			flagA_reg <= 1'b0;
			flagB_reg <= 1'b0;
		end else begin
			eqA_reg <= eqA;
			eqB_reg <= eqB;
			flagA_reg <= flagA_next;
			flagB_reg <= flagB_next;
		end
	end

	// Pin outputs start low until a match
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pinAOut_reg <= 1'b0; // see R16
			pinBOut_reg <= 1'b0; // see R16
			pinAOe_reg <= 1'b0;
			pinBOe_reg <= 1'b0;
		end else begin
			pinAOut_reg <= pinAOut_next;
			pinBOut_reg <= pinBOut_next;
			pinAOe_reg <= pinAOe_next;
			pinBOe_reg <= pinBOe_next;
		end
	end

	// Sync clear out and read data
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			syncClear_reg <= 1'b0;
			rdData_reg <= 16'h0000;
		end else begin
			syncClear_reg <= clearOwn;
			rdData_reg <= rdData_next;
		end
	end

	// Outputs straight from flops
	assign pinAOut = pinAOut_reg;
	assign pinBOut = pinBOut_reg;
	assign pinAOe = pinAOe_reg;
	assign pinBOe = pinBOe_reg;
	assign syncClearOut = syncClear_reg;
	assign rdData = rdData_reg;
endmodule : tcc_channel

/* File: hdl/tcc_pin_sync.sv */
/*
 Two-stage synchroniser with edge detection for one pin.
 Assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/10ps
module tcc_pin_sync (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic asyncIn,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Two flops, then one history flop for edges
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= asyncIn;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// Edges seen only on the second stage
	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
	assign fall = ~sync_reg & last_reg;
endmodule : tcc_pin_sync

/* File: hdl/tcc_pkg.sv */
/*
 Constants for one capture/compare timer channel: register
 indices, field positions, reset values and function codes.
 Assumes a 3-bit register index and a 16-bit register port.
*/
package tcc_pkg;
	// Register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;

	// Register indices
	localparam logic [2:0] REG_CLK_SEL = 3'h0;
	localparam logic [2:0] REG_PIN_FUNC = 3'h1;
	localparam logic [2:0] REG_COUNTER = 3'h2;
	localparam logic [2:0] REG_GEN_A = 3'h3;
	localparam logic [2:0] REG_GEN_B = 3'h4;
	localparam logic [2:0] REG_FLAGS = 3'h5;

	// Clock select control fields
	localparam int CLR_LO = 5;
	localparam int EDGE_LO = 3;
	localparam int SRC_LO = 0;
	localparam int SRC_EXT_BIT = 2;
	localparam logic [7:0] CLK_SEL_RST = 8'h00;
	localparam logic [7:0] CLK_SEL_FIXED = 8'h80;

	// Pin function control fields
	localparam int FUNC_A_LO = 0;
	localparam int FUNC_B_LO = 4;
	localparam int FUNC_FIXED_BIT = 3;
	localparam int FUNC_SPARE_BIT = 7;
	localparam logic [7:0] PIN_FUNC_RST = 8'h88;

	// Flag register fields
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_B_BIT = 1;

	// Counter clear sources
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_GEN_A = 2'h1;
	localparam logic [1:0] CLR_GEN_B = 2'h2;
	localparam logic [1:0] CLR_SYNC = 2'h3;

	// External edge choices
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam int EDGE_BOTH_BIT = 1;

	// Internal divider choices
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	localparam logic [1:0] DIV_8 = 2'h3;

	// General register function codes
	localparam logic [2:0] FUNC_OC_OFF = 3'h0;
	localparam logic [2:0] FUNC_OC_LOW = 3'h1;
	localparam logic [2:0] FUNC_OC_HIGH = 3'h2;
	localparam logic [2:0] FUNC_OC_TOGGLE = 3'h3;
	localparam logic [2:0] FUNC_IC_RISE = 3'h4;
	localparam logic [2:0] FUNC_IC_FALL = 3'h5;
	localparam logic [2:0] FUNC_IC_BOTH = 3'h6;
	localparam int FUNC_CAPTURE_BIT = 2;

	// Channel numbers with special behaviour
	localparam int CHAN_PHASE = 2;
	localparam int CHAN_PWM_LO = 3;
	localparam int CHAN_PWM_HI = 4;

	// Pin sampling inputs: ext clocks A..D, then pins A, B
	localparam int N_PINS = 6;
	localparam int PIN_A_IDX = 4;
	localparam int PIN_B_IDX = 5;
endpackage : tcc_pkg

/* File: hdl/tcc_prescaler.sv */
/*
 Internal clock divider giving one tick per falling edge of
 the divided clock (by 1, 2, 4 or 8). Assumes mclk is the
 internal system clock.
*/
`timescale 1ns/10ps
module tcc_prescaler (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] divSel,
	output logic tick
);
	logic [2:0] div_reg;

	// Free-running divider chain
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end

	// Divided clock bit falls when lower bits are all ones
	assign tick = (divSel == tcc_pkg::DIV_1) ? 1'b1 :
		(divSel == tcc_pkg::DIV_2) ? div_reg[0] :
		(divSel == tcc_pkg::DIV_4) ? &div_reg[1:0] :
		&div_reg;
endmodule : tcc_prescaler

/* File: sim/tcc_channel_sva.sv */
/*
 Port checker for one timer channel, bound to tcc_channel.
 Assumes one mclk domain and nrst asynchronous, active low.
*/
`timescale 1ns/10ps
module tcc_channel_sva #(
	parameter int CHAN_ID = 0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [15:0] rdData,
	input wire logic pinAOut,
	input wire logic pinAOe,
	input wire logic pinBOe,
	input wire logic pwmPairMode,
	input wire logic syncClearOut
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Pin function write outside paired PWM
	wire pfWr = wrStb && addr == tcc_pkg::REG_PIN_FUNC && !pwmPairMode;
	wire genAWr = wrStb && addr == tcc_pkg::REG_GEN_A;
	wire genARd = rdStb && addr == tcc_pkg::REG_GEN_A;

	rd_idle_zero_a: assert property (!rdStb |=> rdData == 16'h0000)
		else $error("read data not zero outside a read");
	pin_fixed_bit_a: assert property (
		rdStb && addr == tcc_pkg::REG_PIN_FUNC |=> rdData[3] && !rdData[8])
		else $error("pin function fixed bit not set");
	unmapped_zero_a: assert property (rdStb && addr > 3'h5 |=> !rdData)
		else $error("unmapped read not zero");
	gen_readback_a: assert property (
		genAWr ##2 genARd |=> rdData == $past(wrData, 3))
		else $error("register A read back differs");
	a_compare_oe_a: assert property (
		pfWr && !wrData[2] && wrData[1:0] != 2'h0 |-> ##[1:2] pinAOe)
		else $error("pin A not driven in compare use");
	a_capture_oe_a: assert property (
		pfWr && wrData[2] |-> ##[1:2] !pinAOe)
		else $error("pin A driven in capture use");
	b_compare_oe_a: assert property (
		pfWr && !wrData[6] && wrData[5:4] != 2'h0 |-> ##[1:2] pinBOe)
		else $error("pin B not driven in compare use");
	sync_pulse_a: assert property (syncClearOut |=> !syncClearOut)
		else $error("clear pulse longer than one cycle");
	out_on_match_a: assert property ($changed(pinAOut) |-> pinAOe)
		else $error("pin A changed while not driven");

	// Main scenarios reached
	cover property ($rose(pinAOut));
	cover property (syncClearOut);
	cover property (genAWr ##2 genARd);
endmodule : tcc_channel_sva

bind tcc_channel tcc_channel_sva #(.CHAN_ID(CHAN_ID)) chkInst (
	.mclk(mclk), .nrst(nrst), .addr(addr), .wrData(wrData),
	.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
	.pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOe(pinBOe),
	.pwmPairMode(pwmPairMode), .syncClearOut(syncClearOut)
);

/* File: sim/tcc_channel_tb_top.sv */
/*
 Self-checking bench for one timer channel (channel 0).
 Assumes the pin model and the bound port checker are compiled.
*/
`timescale 1ns/10ps
module tcc_channel_tb_top;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wrData = 16'h0000;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic modeOff = 1'b0;
	logic syncSel = 1'b0;
	logic syncReq = 1'b0;
	logic [15:0] rdData;
	logic [3:0] extClkIn;
	logic pinAIn, pinBIn, pinAOut, pinAOe, pinBOut, pinBOe;
	logic [15:0] d0, d1;
	int n_fail = 0;
	int n_tests = 0;
	logic [2:0] ocCode [4] = '{3'h2, 3'h1, 3'h3, 3'h3};
	logic [15:0] ocOut [4] = '{16'h0003, 16'h0000, 16'h0003, 16'h0000};
	logic [15:0] capExp [4] = '{16'h0011, 16'h0022, 16'h0022, 16'h0000};
	logic [15:0] clrExp [4] = '{16'h0022, 16'h0000, 16'h0000, 16'h0022};

	// 200 MHz clock
	always #2.5 mclk = ~mclk;

	tcc_channel #(.CHAN_ID(0)) dut (
		.mclk(mclk), .nrst(nrst), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.extClkIn(extClkIn), .pinAIn(pinAIn), .pinBIn(pinBIn),
		.pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOut(pinBOut),
		.pinBOe(pinBOe), .phaseCountMode(modeOff), .pwmPairMode(modeOff),
		.syncSelect(syncSel), .syncClearIn(syncReq), .syncClearOut()
	);

	tcc_pin_model pm (
		.mclk(mclk), .extClkIn(extClkIn), .pinAIn(pinAIn), .pinBIn(pinBIn)
	);

	// Counts, verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	// One-cycle register write
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge mclk);
		wrStb <= 1'b0;
		#1;
	endtask : wr

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1 d = rdData;
	endtask : rd

	// One-cycle clear request from the synchronised counters
	task automatic syncPulse(input logic sel);
		@(posedge mclk);
		syncSel <= sel;
		syncReq <= 1'b1;
		@(posedge mclk);
		syncReq <= 1'b0;
	endtask : syncPulse

	task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rdChk

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		rdChk(tcc_pkg::REG_CLK_SEL, 16'h0080);
		rdChk(tcc_pkg::REG_PIN_FUNC, 16'h0088);
		rdChk(tcc_pkg::REG_FLAGS, 16'h0000);
		rdChk(3'h6, 16'h0000);
		wr(tcc_pkg::REG_PIN_FUNC, 16'h0000);
		rdChk(tcc_pkg::REG_PIN_FUNC, 16'h0008);
		// Internal divider ticks over 16 cycles, edge field set to both
		for (int k = 0; k < 4; k++) begin
			wr(tcc_pkg::REG_CLK_SEL, 16'h0010 + 16'(k));
			rd(tcc_pkg::REG_COUNTER, d0);
			repeat (14) @(posedge mclk);
			rd(tcc_pkg::REG_COUNTER, d1);
			chk(d1 - d0, 16'h0010 >> k);
		end
		// External sources A to D with each edge choice
		for (int k = 0; k < 4; k++) begin
			wr(tcc_pkg::REG_CLK_SEL, {11'h000, 2'(k), 1'b1, 2'(k)});
			wr(tcc_pkg::REG_COUNTER, 16'h0000);
			pm.clkPulses(k, 3);
			rdChk(tcc_pkg::REG_COUNTER, (k > 1) ? 16'h0006 : 16'h0003);
		end
		// Compare output on both pins, clear from register A or B
		wr(tcc_pkg::REG_GEN_A, 16'h0005);
		rdChk(tcc_pkg::REG_GEN_A, 16'h0005);
		wr(tcc_pkg::REG_GEN_B, 16'h0005);
		for (int k = 0; k < 4; k++) begin
			wr(tcc_pkg::REG_CLK_SEL, (k % 2) ? 16'h0044 : 16'h0024);
			wr(tcc_pkg::REG_PIN_FUNC, {9'h000, ocCode[k], 1'b1, ocCode[k]});
			if (k == 0) chk({14'h0, pinBOut, pinAOut}, 16'h0000);
			wr(tcc_pkg::REG_COUNTER, 16'h0004);
			pm.clkPulses(0, 1);
			rdChk(tcc_pkg::REG_COUNTER, 16'h0000);
			chk({14'h0, pinBOut, pinAOut}, ocOut[k]);
			chk({14'h0, pinBOe, pinAOe}, 16'h0003);
		end
		rdChk(tcc_pkg::REG_FLAGS, 16'h0003);
		wr(tcc_pkg::REG_FLAGS, 16'h0000);
		rdChk(tcc_pkg::REG_FLAGS, 16'h0000);
		// Capture codes on pins A and B, counter moved between the edges
		for (int k = 0; k < 4; k++) begin
			wr(tcc_pkg::REG_PIN_FUNC, 16'h0008 + 16'((k + 4) * 17));
			wr(tcc_pkg::REG_GEN_A, 16'h0000);
			wr(tcc_pkg::REG_GEN_B, 16'h0000);
			wr(tcc_pkg::REG_COUNTER, 16'h0011);
			pm.setCapPins(1'b1);
			wr(tcc_pkg::REG_COUNTER, 16'h0022);
			pm.setCapPins(1'b0);
			rdChk(tcc_pkg::REG_GEN_A, capExp[k]);
			rdChk(tcc_pkg::REG_GEN_B, capExp[k]);
			rdChk(tcc_pkg::REG_COUNTER, clrExp[k]);
		end
		// Synchronised clear needs the select input
		wr(tcc_pkg::REG_CLK_SEL, 16'h0064);
		wr(tcc_pkg::REG_COUNTER, 16'h0033);
		syncPulse(1'b0);
		rdChk(tcc_pkg::REG_COUNTER, 16'h0033);
		syncPulse(1'b1);
		rdChk(tcc_pkg::REG_COUNTER, 16'h0000);
		report_and_stop();
	end
endmodule : tcc_channel_tb_top

/* File: sim/tcc_pin_model.sv */
/*
 Pin side model: four external clock lines and capture pins A, B.
 Assumes the bench calls its tasks; lines rest low between frames.
*/
`timescale 1ns/10ps
module tcc_pin_model (
	input wire logic mclk,
	output logic [3:0] extClkIn,
	output logic pinAIn,
	output logic pinBIn
);
	// All lines idle low from time zero
	initial begin
		extClkIn = 4'h0;
		pinAIn = 1'b0;
		pinBIn = 1'b0;
	end

	// Full clock periods, eight cycles each, then the line stands low
	task automatic clkPulses(input int idx, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge mclk);
			extClkIn[idx] <= 1'b1;
			repeat (4) @(posedge mclk);
			extClkIn[idx] <= 1'b0;
		end
		repeat (6) @(posedge mclk);
	endtask : clkPulses

	// Level change on both capture pins, held long enough to be synchronised
	task automatic setCapPins(input logic v);
		@(posedge mclk);
		pinAIn <= v;
		pinBIn <= v;
		repeat (6) @(posedge mclk);
	endtask : setCapPins
endmodule : tcc_pin_model
